// [rtl/port_pkg.sv]
// Purpose: Shared constants and carriers for the dual byte I/O port.
// Assumes: APB slave, 32-bit data, register index times four is the byte address.
// Notes:   Mode codes come from strap pins; indices 16'hffc3 and 16'hffc4 are local.
`default_nettype none
package port_pkg;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 32;
   // Register indices; byte address is index * 4.
   localparam logic [15:0] IDX_PA_PCR = 16'hffae;
   localparam logic [15:0] IDX_PA_DDR = 16'hffb4;
   localparam logic [15:0] IDX_PB_DDR = 16'hffb5;
   localparam logic [15:0] IDX_PA_DR  = 16'hffb6;
   localparam logic [15:0] IDX_PB_DR  = 16'hffb7;
   localparam logic [15:0] IDX_SYSTEM_CONTROL_REGISTER  = 16'hffc3;
   localparam logic [15:0] IDX_STATUS = 16'hffc4;
   // Reset values and fixed read values.
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] DDR_READ  = 8'hff;
   localparam logic       RST_HIE   = 1'b0;
   // Field positions.
   localparam int unsigned HIE_POS   = 0;
   localparam int unsigned ST_MODE_LO = 0;
   localparam int unsigned ST_SLAVE  = 2;
   localparam int unsigned ST_SWSBY  = 3;
   localparam int unsigned PB_HIRQ_LO = 3;
   localparam int unsigned PB_HIRQ_HI = 5;
   localparam int unsigned PB_TMO    = 4;
   localparam int unsigned PB_PW0    = 6;
   localparam int unsigned PB_PW1    = 7;
   // Strap codes of the operating mode.
   localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
   localparam logic [1:0] MODE_EXP_ROM   = 2'h2;
   localparam logic [1:0] MODE_SINGLE    = 2'h3;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic              pready;
      logic [DATA_W-1:0] prdata;
      logic              pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } byte_pins_t;
endpackage
`default_nettype wire

// [rtl/dual_byte_io_port.sv]
// Purpose: Two 8-bit I/O ports with direction and data control, plus port A pull-up control, over APB.
// Assumes: Standby inputs and bus-side inputs come from logic on mclk.
// Notes:   Pin levels and mode straps pass a two-stage synchroniser first.
//
// Implementation choice: the APB slave port.
`default_nettype none

// Notes on behaviour
// - Port A direction register is write-only and reads as all ones.
// - Expanded modes ignore port A direction; pins form the external data bus.
// - Port A data bus pins float during reset, hardware and software standby; slave mode still drives the host data bus in software standby.
// - Single-chip, host off: port A pin outputs data when direction is one.
// - Port A direction clears on reset and hardware standby, kept in software standby.
// - Port A data read gives stored bit for outputs, pin level for inputs.
// - Port A data clears on reset and hardware standby, kept in software standby.
// - Port A pull-up is on only for input pins with pull-up bit set.
// - Pull-up control clears on reset and hardware standby, kept in software standby.
// - Pull-ups off in expanded modes, during reset and hardware standby.
// - Pull-ups off while the host interface is enabled in slave mode.
// - Single-chip host enable turns port A into the host data bus.
// - Unclaimed port B pin outputs data when direction is one, else input.
// - Port B direction register is write-only and reads as all ones.
// - Port B direction clears on reset and hardware standby, kept in software standby.
// - Software standby reinitialises peripherals; port B pins revert to plain I/O.
// - Port B data read gives stored bit for outputs, pin level for inputs.
// - Port B data clears on reset and hardware standby, kept in software standby.
// - Slave mode drives host interrupt requests on port B bits 3 to 5 whose direction bit is one.
module dual_byte_io_port (
   // Clock and reset.
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // Register bus.
   input  wire port_pkg::apb_req_t   apb_req,
   output var  port_pkg::apb_rsp_t   apb_rsp,
   // Operating mode strap and standby controls.
   input  wire logic [1:0]           op_mode_strap,
   input  wire logic                 hw_standby,
   input  wire logic                 sw_standby,
   // External data bus of the expanded modes.
   input  wire logic [7:0]           ext_bus_wdata,
   input  wire logic                 ext_bus_drive,
   output logic [7:0]                ext_bus_rdata,
   // Host side data bus of slave mode.
   input  wire logic [7:0]           host_side_data_bus_wdata,
   input  wire logic                 host_side_data_bus_drive,
   output logic [7:0]                host_side_data_bus_rdata,
   // Port A pins.
   input  wire logic [7:0]           pa_pin_in,
   output var  port_pkg::byte_pins_t pa_pin,
   output logic [7:0]                pa_pullup_en,
   // Port B peripheral sources.
   input  wire logic                 timer_compare_output,
   input  wire logic                 timer_compare_enable,
   input  wire logic [1:0]           pwm_output,
   input  wire logic [1:0]           pwm_output_enable,
   input  wire logic [2:0]           host_irq,
   output logic                      periph_reinit,
   // Port B pins.
   input  wire logic [7:0]           pb_pin_in,
   output var  port_pkg::byte_pins_t pb_pin
);
   import port_pkg::*;

   logic [7:0]  pa_meta_q;
   logic [7:0]  pa_sync_q;
   logic [7:0]  pb_meta_q;
   logic [7:0]  pb_sync_q;
   logic [1:0]  mode_meta_q;
   logic [1:0]  mode_sync_q;
   logic [1:0]  mode_q;
   logic [7:0]  pa_ddr_q;
   logic [7:0]  pa_dr_q;
   logic [7:0]  pa_pcr_q;
   logic [7:0]  pb_ddr_q;
   logic [7:0]  pb_dr_q;
   logic        hie_q;
   logic        clear_regs;
   logic        single_chip;
   logic        slave_mode;
   logic        quiet;
   logic        periph_on;
   logic        access;
   logic        wr_en;
   logic        aligned;
   logic [15:0] idx;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte_d;
   logic        hit_d;
   logic [7:0]  pa_read;
   logic [7:0]  pb_read;
   logic [7:0]  pa_out_d;
   logic [7:0]  pa_oe_d;
   logic [7:0]  pa_pu_d;
   logic [7:0]  pb_out_d;
   logic [7:0]  pb_oe_d;
   logic        ready_q;
   logic [31:0] rdata_q;
   logic        slverr_q;

   // Pin levels and straps are asynchronous to mclk.
   always_ff @(posedge mclk) begin
      pa_meta_q   <= pa_pin_in;
      pa_sync_q   <= pa_meta_q;
      pb_meta_q   <= pb_pin_in;
      pb_sync_q   <= pb_meta_q;
      mode_meta_q <= op_mode_strap;
      mode_sync_q <= mode_meta_q;
   end

   // The strap is caught while reset is held and frozen afterwards.
   always_ff @(posedge mclk) begin
      if (srst) begin
         mode_q <= mode_sync_q;
      end
   end

   assign single_chip = (mode_q == MODE_SINGLE);
   assign slave_mode  = single_chip & hie_q;
   assign clear_regs  = srst | hw_standby;
   assign quiet       = srst | hw_standby | sw_standby;
   assign periph_on   = ~sw_standby;

   // Bus decode.
   assign access  = apb_req.psel & apb_req.penable;
   assign wr_en   = access & ready_q & apb_req.pwrite & ~hw_standby;
   assign idx     = apb_req.paddr[ADDR_W-1:2];
   assign aligned = (apb_req.paddr[1:0] == 2'h0);
   assign wbyte   = apb_req.pwdata[7:0];

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pa_ddr_q <= RST_BYTE;
      end else if (wr_en && aligned && idx == IDX_PA_DDR) begin
         pa_ddr_q <= wbyte;
      end
   end

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pa_dr_q <= RST_BYTE;
      end else if (wr_en && aligned && idx == IDX_PA_DR) begin
         pa_dr_q <= wbyte;
      end
   end

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pa_pcr_q <= RST_BYTE;
      end else if (wr_en && aligned && idx == IDX_PA_PCR) begin
         pa_pcr_q <= wbyte;
      end
   end

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pb_ddr_q <= RST_BYTE;
      end else if (wr_en && aligned && idx == IDX_PB_DDR) begin
         pb_ddr_q <= wbyte;
      end
   end

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pb_dr_q <= RST_BYTE;
      end else if (wr_en && aligned && idx == IDX_PB_DR) begin
         pb_dr_q <= wbyte;
      end
   end

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         hie_q <= RST_HIE;
      end else if (wr_en && aligned && idx == IDX_SYSTEM_CONTROL_REGISTER) begin
         hie_q <= wbyte[HIE_POS];
      end
   end

   // Data reads mix stored outputs with synchronised input levels.
   assign pa_read = (pa_dr_q & pa_ddr_q) | (pa_sync_q & ~pa_ddr_q);
   assign pb_read = (pb_dr_q & pb_ddr_q) | (pb_sync_q & ~pb_ddr_q);

   always_comb begin
      rbyte_d = RST_BYTE;
      hit_d   = aligned;
      unique case (idx)
         IDX_PA_DDR: rbyte_d = DDR_READ;
         IDX_PB_DDR: rbyte_d = DDR_READ;
         IDX_PA_DR:  rbyte_d = pa_read;
         IDX_PB_DR:  rbyte_d = pb_read;
         IDX_PA_PCR: rbyte_d = pa_pcr_q;
         IDX_SYSTEM_CONTROL_REGISTER:  rbyte_d[HIE_POS] = hie_q;
         IDX_STATUS: begin
            rbyte_d[ST_MODE_LO +: 2] = mode_q;
            rbyte_d[ST_SLAVE]        = slave_mode;
            rbyte_d[ST_SWSBY]        = sw_standby;
         end
         default:    hit_d = 1'b0;
      endcase
   end

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ready_q  <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else if (access && !ready_q) begin
         ready_q  <= 1'b1;
         rdata_q  <= {24'h00_0000, (apb_req.pwrite || !hit_d) ? 8'h00 : rbyte_d};
         slverr_q <= ~hit_d;
      end else begin
         ready_q  <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end
   end

   always_comb begin
      apb_rsp.pready  = ready_q;
      apb_rsp.prdata  = rdata_q;
      apb_rsp.pslverr = slverr_q;
   end

   // Port A ownership per pin.
   generate
      for (genvar i = 0; i < 8; i++) begin : g_pa
         always_comb begin
            pa_out_d[i] = 1'b0;
            pa_oe_d[i]  = 1'b0;
            pa_pu_d[i]  = 1'b0;
            if (!single_chip) begin
               // Expanded modes: direction bits play no part.
               pa_out_d[i] = ext_bus_wdata[i];
               pa_oe_d[i]  = ext_bus_drive & ~quiet;
            end else if (slave_mode) begin
               pa_out_d[i] = host_side_data_bus_wdata[i];
               pa_oe_d[i]  = host_side_data_bus_drive & ~hw_standby;
               pa_pu_d[i]  = 1'b0;
            end else begin
               pa_out_d[i] = pa_dr_q[i];
               pa_oe_d[i]  = pa_ddr_q[i];
               pa_pu_d[i]  = ~pa_ddr_q[i] & pa_pcr_q[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pa_pin.out   <= RST_BYTE;
         pa_pin.oe    <= RST_BYTE;
         pa_pullup_en <= RST_BYTE;
      end else begin
         pa_pin.out   <= pa_out_d;
         pa_pin.oe    <= pa_oe_d;
         pa_pullup_en <= pa_pu_d;
      end
   end

   // Bus read data follows the synchronised pin levels.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ext_bus_rdata            <= RST_BYTE;
         host_side_data_bus_rdata <= RST_BYTE;
      end else begin
         ext_bus_rdata            <= single_chip ? RST_BYTE : pa_sync_q;
         host_side_data_bus_rdata <= slave_mode ? pa_sync_q : RST_BYTE;
      end
   end

   // Port B ownership per pin; peripherals lose their pins in software standby.
   generate
      for (genvar j = 0; j < 8; j++) begin : g_pb
         always_comb begin
            pb_out_d[j] = pb_dr_q[j];
            pb_oe_d[j]  = pb_ddr_q[j];
            if (j == PB_PW1 && pwm_output_enable[1] && periph_on) begin
               pb_out_d[j] = pwm_output[1];
               pb_oe_d[j]  = 1'b1;
            end else if (j == PB_PW0 && pwm_output_enable[0] && periph_on) begin
               pb_out_d[j] = pwm_output[0];
               pb_oe_d[j]  = 1'b1;
            end else if (j == PB_TMO && timer_compare_enable && periph_on) begin
               pb_out_d[j] = timer_compare_output;
               pb_oe_d[j]  = 1'b1;
            end else if (j >= PB_HIRQ_LO && j <= PB_HIRQ_HI && slave_mode
                         && pb_ddr_q[j] && periph_on) begin
               pb_out_d[j] = host_irq[j - PB_HIRQ_LO];
               pb_oe_d[j]  = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (clear_regs) begin
         pb_pin.out    <= RST_BYTE;
         pb_pin.oe     <= RST_BYTE;
         periph_reinit <= 1'b1;
      end else begin
         pb_pin.out    <= pb_out_d;
         pb_pin.oe     <= pb_oe_d;
         periph_reinit <= sw_standby;
      end
   end
endmodule
`default_nettype wire

// [verification/pin_model.sv]
// Purpose: External circuitry on the pins of one 8-bit port.
// Assumes: The outside world drives only the bits named in ext_oe.
// Notes:   A pin nobody drives or pulls up toggles each cycle.
`default_nettype none
module pin_model (
   // Clock.
   input  wire logic                 mclk,
   // Port side.
   input  wire port_pkg::byte_pins_t pin,
   input  wire logic [7:0]           pu,
   // Outside drivers.
   input  wire logic [7:0]           ext_val,
   input  wire logic [7:0]           ext_oe,
   output logic [7:0]                lvl
);
   timeunit 1ns;
   timeprecision 1ns;
   import port_pkg::*;
   logic [7:0] flt_q = 8'h55;
   always_ff @(posedge mclk) begin
      flt_q <= ~flt_q;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         lvl[i] = pin.oe[i] ? pin.out[i] : ext_oe[i] ? ext_val[i] : (pu[i] | flt_q[i]);
      end
   end
endmodule
`default_nettype wire

// [verification/port_monitor.sv]
// Purpose: Port-level checks of the dual byte I/O port.
// Assumes: The mode strap only changes while reset is held.
// Notes:   Bound to the design top.
`default_nettype none
module port_monitor (
   // Clock and reset.
   input wire logic               mclk,
   input wire logic               srst,
   // Register bus.
   input wire port_pkg::apb_req_t apb_req,
   input wire port_pkg::apb_rsp_t apb_rsp,
   // Mode, standby and sources.
   input wire logic [1:0]         op_mode_strap,
   input wire logic               hw_standby,
   input wire logic               sw_standby,
   input wire logic [7:0]         ext_bus_wdata,
   input wire logic               ext_bus_drive,
   input wire logic [1:0]         pwm_output,
   input wire logic [1:0]         pwm_output_enable,
   // Pins.
   input wire port_pkg::byte_pins_t pa_pin,
   input wire logic [7:0]         pa_pullup_en,
   input wire port_pkg::byte_pins_t pb_pin,
   input wire logic               periph_reinit
);
   import port_pkg::*;
   localparam logic [17:0] A_DDR = {IDX_PA_DDR, 2'b00};
   localparam logic [17:0] B_DDR = {IDX_PB_DDR, 2'b00};
   logic expd;
   assign expd = op_mode_strap != MODE_SINGLE;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_ddr_rd;
      apb_req.psel && !apb_req.penable && !apb_req.pwrite
      && (apb_req.paddr == A_DDR || apb_req.paddr == B_DDR)
      ##1 apb_req.psel && apb_req.penable ##1 apb_rsp.pready;
   endsequence
   a_ddr_reads_ones: assert property (s_ddr_rd |-> apb_rsp.prdata == {24'h0, DDR_READ})
      else $error("direction read not all ones");
   a_pu_input_only: assert property ((pa_pullup_en & pa_pin.oe) == 8'h00)
      else $error("pull-up on a driven pin");
   a_hws_all_off: assert property (hw_standby |=> {pa_pin.oe, pb_pin.oe, pa_pullup_en} == 24'h0)
      else $error("pins not released in hardware standby");
   a_exp_no_pullup: assert property (expd |-> pa_pullup_en == 8'h00)
      else $error("pull-up on in expanded mode");
   a_exp_bus_drive: assert property (expd && !hw_standby && !sw_standby && ext_bus_drive |=>
      pa_pin.oe == 8'hff && pa_pin.out == $past(ext_bus_wdata))
      else $error("data bus not driven");
   a_exp_sws_float: assert property (expd && sw_standby |=> pa_pin.oe == 8'h00)
      else $error("data bus driven in software standby");
   a_pwm_claim: assert property (pwm_output_enable[1] && !sw_standby && !$past(sw_standby)
      && !hw_standby |=> pb_pin.oe[7] && pb_pin.out[7] == $past(pwm_output[1]))
      else $error("pwm pin not claimed");
   a_sws_reinit: assert property (sw_standby |=> periph_reinit)
      else $error("peripherals not reinitialised");
endmodule
bind dual_byte_io_port port_monitor mon_u (
   .mclk(mclk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .op_mode_strap(op_mode_strap), .hw_standby(hw_standby), .sw_standby(sw_standby),
   .ext_bus_wdata(ext_bus_wdata), .ext_bus_drive(ext_bus_drive), .pwm_output(pwm_output),
   .pwm_output_enable(pwm_output_enable), .pa_pin(pa_pin), .pa_pullup_en(pa_pullup_en),
   .pb_pin(pb_pin), .periph_reinit(periph_reinit));
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench of the dual byte I/O port.
// Assumes: Pins follow a register write one edge after it lands.
// Notes:   Scenarios run in order and share the register state.
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import port_pkg::*;
   localparam logic [17:0] A_PCR = {IDX_PA_PCR, 2'b00};
   localparam logic [17:0] A_DDR = {IDX_PA_DDR, 2'b00};
   localparam logic [17:0] B_DDR = {IDX_PB_DDR, 2'b00};
   localparam logic [17:0] A_DR  = {IDX_PA_DR, 2'b00};
   localparam logic [17:0] B_DR  = {IDX_PB_DR, 2'b00};
   localparam logic [17:0] SYS   = {IDX_SYSTEM_CONTROL_REGISTER, 2'b00};
   apb_req_t    req = '0;
   apb_rsp_t    rsp;
   byte_pins_t  pa, pb;
   logic        mclk = 1'b0, srst = 1'b1, hw = 1'b0, sw = 1'b0, ebd = 1'b0, hbd = 1'b0;
   logic        reinit, serr;
   logic [7:0]  ewd = 8'h0, hwd = 8'h0, erd, hrd, pa_in, pb_in, pa_pu;
   logic [7:0]  ava = 8'h3c, aoe = 8'hff, bva = 8'h5a, boe = 8'h70;
   logic [1:0]  mode = MODE_SINGLE, pwm = 2'b11, pwme = 2'b00;
   logic [2:0]  hirq = 3'b000;
   logic [31:0] rdat;
   int          n_fail = 0, checked = 0;
   dual_byte_io_port dut_u (
      .mclk(mclk), .srst(srst), .apb_req(req), .apb_rsp(rsp), .op_mode_strap(mode),
      .hw_standby(hw), .sw_standby(sw), .ext_bus_wdata(ewd), .ext_bus_drive(ebd),
      .ext_bus_rdata(erd), .host_side_data_bus_wdata(hwd), .host_side_data_bus_drive(hbd),
      .host_side_data_bus_rdata(hrd), .pa_pin_in(pa_in), .pa_pin(pa), .pa_pullup_en(pa_pu),
      .timer_compare_output(1'b0), .timer_compare_enable(1'b0), .pwm_output(pwm),
      .pwm_output_enable(pwme), .host_irq(hirq), .periph_reinit(reinit),
      .pb_pin_in(pb_in), .pb_pin(pb));
   pin_model pa_u (.mclk(mclk), .pin(pa), .pu(pa_pu), .ext_val(ava), .ext_oe(aoe), .lvl(pa_in));
   pin_model pb_u (.mclk(mclk), .pin(pb), .pu(8'h00), .ext_val(bva), .ext_oe(boe), .lvl(pb_in));
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge mclk);
      req.penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready.
      do begin
         @(posedge mclk);
      end while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      serr = rsp.pslverr;
      req <= '0;
   endtask
   task automatic t_reset();
      apb(1'b0, A_PCR, 8'h00);
      `CHK(rdat, 32'h0)
      apb(1'b0, A_DDR, 8'h00);
      `CHK(rdat, 32'hff)
      apb(1'b0, B_DDR, 8'h00);
      `CHK(rdat, 32'hff)
      apb(1'b0, A_DR, 8'h00);
      `CHK(rdat, 32'h3c)
      `CHK({pa.oe, pb.oe}, 16'h0)
   endtask
   task automatic t_gpio();
      aoe <= 8'hf0;
      apb(1'b1, A_DR, 8'ha5);
      apb(1'b1, A_DDR, 8'h0f);
      apb(1'b1, A_PCR, 8'hff);
      step(2);
      `CHK({pa.oe, pa.out[3:0]}, 12'h0f5)
      `CHK(pa_pu, 8'hf0)
      apb(1'b0, A_PCR, 8'h00);
      `CHK(rdat, 32'hff)
      apb(1'b0, A_DR, 8'h00);
      `CHK(rdat, 32'h35)
   endtask
   task automatic t_pb();
      pwme <= 2'b10;
      apb(1'b1, B_DR, 8'h03);
      apb(1'b1, B_DDR, 8'h0f);
      step(4);
      `CHK(pb.oe, 8'h8f)
      `CHK({pb.out[7], pb.out[3:0]}, 5'h13)
      apb(1'b0, B_DR, 8'h00);
      `CHK(rdat, 32'hd3)
   endtask
   task automatic t_sws();
      sw <= 1'b1;
      step(3);
      `CHK({pa.oe, pa_pu, pb.oe}, 24'h0ff00f)
      `CHK(reinit, 1'b1)
      sw <= 1'b0;
      pwme <= 2'b00;
      apb(1'b0, A_DR, 8'h00);
      `CHK(rdat, 32'h35)
      apb(1'b0, B_DR, 8'h00);
      `CHK(rdat[3:0], 4'h3)
   endtask
   task automatic t_host();
      aoe <= 8'h00;
      hbd <= 1'b1;
      hwd <= 8'h96;
      hirq <= 3'b001;
      apb(1'b1, SYS, 8'h01);
      step(2);
      `CHK({pa.oe, pa.out, pa_pu}, 24'hff9600)
      `CHK({pb.oe[5:3], pb.out[3]}, 4'h3)
      hbd <= 1'b0;
      aoe <= 8'hff;
      ava <= 8'h69;
      step(5);
      `CHK(hrd, 8'h69)
      aoe <= 8'hf0;
      apb(1'b1, SYS, 8'h00);
      step(2);
      `CHK(pa.oe, 8'h0f)
   endtask
   task automatic t_hws();
      hw <= 1'b1;
      aoe <= 8'h00;
      boe <= 8'h00;
      step(2);
      hw <= 1'b0;
      apb(1'b0, A_PCR, 8'h00);
      `CHK(rdat, 32'h0)
      `CHK({pa.oe, pb.oe}, 16'h0)
      apb(1'b1, A_DDR, 8'hff);
      apb(1'b1, B_DDR, 8'hff);
      step(2);
      `CHK({pa.out, pb.out}, 16'h0)
   endtask
   task automatic t_exp();
      apb(1'b0, 18'h3ff20, 8'h00);
      `CHK({serr, rdat}, 33'h100000000)
      mode <= MODE_EXP_ROM;
      srst <= 1'b1;
      step(8);
      srst <= 1'b0;
      apb(1'b1, A_DDR, 8'h0f);
      apb(1'b1, A_PCR, 8'hff);
      step(2);
      `CHK({pa.oe, pa_pu}, 16'h0)
      ebd <= 1'b1;
      ewd <= 8'hc3;
      step(2);
      `CHK({pa.oe, pa.out}, 16'hffc3)
      step(3);
      `CHK(erd, 8'hc3)
      sw <= 1'b1;
      step(2);
      `CHK(pa.oe, 8'h00)
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge mclk);
      n_fail++;
      print_verdict();
   end
   initial begin
      step(8);
      srst <= 1'b0;
      t_reset();
      t_gpio();
      t_pb();
      t_sws();
      t_host();
      t_hws();
      t_exp();
      print_verdict();
   end
endmodule
`default_nettype wire
